// >>> design/bus_clock_divider.sv
// external bus clock divider with a pulse on each rising edge
module bus_clock_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and clock out
  input wire logic en,
  output logic ext_bus_clock,
  output logic tick
);
  logic [3:0] cnt;

  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      cnt <= 4'h0;
      ext_bus_clock <= 1'b0;
      tick <= 1'b0;
    end else if (cnt == ext_bus_pkg::BUS_CLK_HALF - 4'h1) begin
      cnt <= 4'h0;
      ext_bus_clock <= !ext_bus_clock;
      tick <= !ext_bus_clock;
    end else begin
      cnt <= cnt + 4'h1;
      tick <= 1'b0;
    end
  end
endmodule

// >>> design/ext_bus_mode_select.sv
// strap-selected external bus port: host slave and memory master roles
module ext_bus_mode_select (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // mode straps
  input wire logic ifcRoleSelect,
  input wire logic memctlTypeSelect,
  input wire logic hostSyncSelect,
  input wire logic addrDataMuxSelect,
  input wire logic strobeFunctionSelect,
  input wire logic bootSelect0,
  input wire logic bootSelect1,
  input wire logic hostBus32,
  // host port pins
  input wire logic hostClk,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic hostAdvN,
  input wire logic [3:0] hostStrobeN,
  input wire logic [ext_bus_pkg::HADDR_HI:1] hostAddrLine,
  input wire logic [ext_bus_pkg::DATA_W-1:0] hostDataIn,
  output logic [ext_bus_pkg::DATA_W-1:0] hostDataOut,
  output logic hostDataOeN,
  output logic hostErrorOutN,
  // host side requests into the device
  output logic hostReqValid,
  output ext_bus_pkg::host_req_s hostReq,
  input wire logic [ext_bus_pkg::DATA_W-1:0] hostRdData,
  // master requests from the device
  input wire logic memReqValid,
  input wire ext_bus_pkg::mem_req_s memReq,
  output logic memReqReady,
  output logic memRespValid,
  output logic memRespErr,
  output logic [ext_bus_pkg::DATA_W-1:0] memRespData,
  // memory pins
  output logic extBusClock,
  output logic [ext_bus_pkg::ADDR_W-1:0] memAddr,
  input wire logic [ext_bus_pkg::DATA_W-1:0] memDataIn,
  output logic [ext_bus_pkg::DATA_W-1:0] memDataOut,
  output logic memDataOeN,
  output logic [3:0] memChipSelectN,
  output logic memRdN,
  output logic memWrStrobeN,
  output logic [3:0] memLaneN,
  // status
  output ext_bus_pkg::mode_e modeOut,
  output logic cfgError,
  output logic bootFromCs0,
  output logic pageModeActive
);
  ext_bus_pkg::strap_s strapSync, strap;
  ext_bus_pkg::host_pins_s hp;
  ext_bus_pkg::mode_e mode;
  ext_bus_pkg::mst_state_e mState;
  ext_bus_pkg::mem_req_s cur;
  logic [ext_bus_pkg::HADDR_HI:1] hAddr;
  logic [ext_bus_pkg::DATA_W-1:0] hData, memDataSync, wrData;
  logic [ext_bus_pkg::ADDR_W-1:0] burstAddr, wrAddr, beatAddr, hStep;
  logic [3:0] wrLanes, hLanes, hReqLanes, beatLanes;
  logic [2:0] settleCnt, holdCnt;
  logic strapsDone, hClkPrev, accPrev, wrPrev, hWr, hRd, hAcc, hRise;
  logic isMaster, isMstAsync, isMstBurst, isBurstSlave, busTick, step;
  logic beat, twoBeats, bootPending;
  logic [ext_bus_pkg::DATA_W-1:0] beatData;

  pin_sync #(.W(8), .RST_VAL(8'h00)) u_strap_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .pinIn({ifcRoleSelect, memctlTypeSelect, hostSyncSelect, addrDataMuxSelect,
            strobeFunctionSelect, bootSelect0, bootSelect1, hostBus32}),
    .pinOut(strapSync)
  );

  pin_sync #(.W(9), .RST_VAL(ext_bus_pkg::HOST_CTL_IDLE)) u_host_ctl_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .pinIn({hostClk, hostCsN, hostRdN, hostWrN, hostAdvN, hostStrobeN}),
    .pinOut(hp)
  );

  // address and data settle long before the strobes that sample them
  pin_sync #(.W(49), .RST_VAL(49'h0)) u_host_ad_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .pinIn({hostAddrLine, hostDataIn}),
    .pinOut({hAddr, hData})
  );

  pin_sync #(.W(32), .RST_VAL(32'h0)) u_mem_data_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .pinIn(memDataIn),
    .pinOut(memDataSync)
  );

  bus_clock_divider u_bus_clk (
    .clk(core_clk),
    .rst_n(rst_n),
    .en(isMstBurst),
    .ext_bus_clock(extBusClock),
    .tick(busTick)
  );

  function automatic ext_bus_pkg::mode_e decodeMode(ext_bus_pkg::strap_s s);
    if (!s.role) begin
      return s.ctlType ? ext_bus_pkg::MODE_MST_BURST : ext_bus_pkg::MODE_MST_ASYNC; // R1
    end else if (!s.ctlType) begin
      return s.hostSync ? ext_bus_pkg::MODE_SLV_SYNC : ext_bus_pkg::MODE_SLV_ASYNC; // R2
    end else if (!s.hostSync) begin
      return ext_bus_pkg::MODE_PROHIBITED; // R5
    end
    return s.admux ? ext_bus_pkg::MODE_SLV_BURST_MUX : ext_bus_pkg::MODE_SLV_BURST_SEP; // R3
  endfunction

  function automatic logic [1:0] firstLane(logic [3:0] l);
    firstLane = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (l[i]) begin
        firstLane = 2'(i);
      end
    end
  endfunction

  // byte address of a host access; low bits come from the lanes in use, except in mux burst where the data lines carry them
  function automatic logic [ext_bus_pkg::ADDR_W-1:0] hostAddr(
    ext_bus_pkg::mode_e m, logic b32, logic [17:1] a, logic [3:0] l, logic [16:0] d);
    logic [ext_bus_pkg::ADDR_W-1:0] base;
    logic [1:0] off;
    off = b32 ? firstLane(l) : (firstLane(l) & 2'h1); // R16
    if (m == ext_bus_pkg::MODE_SLV_BURST_MUX) begin
      return {2'b00, a[17], d}; // R17
    end else if (m == ext_bus_pkg::MODE_SLV_BURST_SEP) begin
      base = b32 ? {1'b0, a[17:1], 2'b00} : {2'b00, a[17:1], 1'b0}; // R18
    end else begin
      base = b32 ? {2'b00, a[17:2], 2'b00} : {2'b00, a[17:1], 1'b0}; // R19
    end
    return base | {18'h0, off};
  endfunction

  // straps are caught once, after the synchronisers have settled
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      settleCnt <= 3'h0;
      strapsDone <= 1'b0;
      strap <= '0;
    end else if (!strapsDone) begin
      // synchroniser output only follows the pins four edges after release
      if (settleCnt == ext_bus_pkg::STRAP_SETTLE) begin
        strapsDone <= 1'b1;
        strap <= strapSync;
      end else begin
        settleCnt <= settleCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode <= ext_bus_pkg::MODE_WAIT;
      modeOut <= ext_bus_pkg::MODE_WAIT;
      cfgError <= 1'b0;
      hostErrorOutN <= 1'b1;
      bootFromCs0 <= 1'b0;
    end else begin
      if (strapsDone) begin
        mode <= decodeMode(strap);
      end
      modeOut <= mode;
      // prohibited straps and strobe pin high in burst both raise cfgError; burst requests still run with the strobe pin high
      cfgError <= (mode == ext_bus_pkg::MODE_PROHIBITED) || (isBurstSlave && strap.strobeFn); // R5 R10
      hostErrorOutN <= !cfgError; // R20
      bootFromCs0 <= isMaster && !strap.boot_select_0 && !strap.boot_select_1; // R11
    end
  end

  assign isMstAsync = (mode == ext_bus_pkg::MODE_MST_ASYNC); // R6
  assign isMstBurst = (mode == ext_bus_pkg::MODE_MST_BURST); // R7
  assign isMaster = isMstAsync || isMstBurst;
  assign isBurstSlave = (mode == ext_bus_pkg::MODE_SLV_BURST_SEP) ||
                        (mode == ext_bus_pkg::MODE_SLV_BURST_MUX); // R3 R4

  // host slave side
  assign hLanes = ~hp.strobeN & (strap.bus32 ? 4'hF : 4'h3);
  assign hWr = strap.strobeFn ? |hLanes : !hp.wrN; // R9
  assign hRd = !hp.rdN;
  assign hAcc = !hp.csN && (hRd || hWr);
  assign hRise = hp.clk && !hClkPrev;
  assign hReqLanes = (strap.strobeFn && !hWr) ? ext_bus_pkg::LANES_ALL : hLanes; // R9
  assign hStep = strap.bus32 ? ext_bus_pkg::ADDR_STEP32 : ext_bus_pkg::ADDR_STEP16;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hostReqValid <= 1'b0;
      hostReq <= '0;
      burstAddr <= ext_bus_pkg::ADDR_ZERO;
      wrAddr <= ext_bus_pkg::ADDR_ZERO;
      wrData <= '0;
      wrLanes <= 4'h0;
      hClkPrev <= 1'b0;
      accPrev <= 1'b0;
      wrPrev <= 1'b0;
    end else begin
      hostReqValid <= 1'b0;
      hClkPrev <= hp.clk;
      accPrev <= hAcc;
      wrPrev <= hWr && !hp.csN;
      if (hWr && !hp.csN) begin
        wrData <= hData;
        wrLanes <= hReqLanes;
        wrAddr <= hostAddr(mode, strap.bus32, hAddr, hReqLanes, hData[16:0]);
      end
      unique case (mode)
        ext_bus_pkg::MODE_SLV_ASYNC: begin
          // async writes are taken when the strobe ends, with the data it held
          if (hAcc && !accPrev && hRd) begin
            hostReqValid <= 1'b1;
            hostReq <= '{hostAddr(mode, strap.bus32, hAddr, hReqLanes, hData[16:0]),
                         hReqLanes, 1'b0, '0}; // R19
          end else if (wrPrev && !(hWr && !hp.csN)) begin
            hostReqValid <= 1'b1;
            hostReq <= '{wrAddr, wrLanes, 1'b1, wrData};
          end
        end
        ext_bus_pkg::MODE_SLV_SYNC: begin
          if (hRise && hAcc) begin
            hostReqValid <= 1'b1;
            hostReq <= '{hostAddr(mode, strap.bus32, hAddr, hReqLanes, hData[16:0]),
                         hReqLanes, hWr, hData}; // R2
          end
        end
        ext_bus_pkg::MODE_SLV_BURST_SEP, ext_bus_pkg::MODE_SLV_BURST_MUX: begin
          if (hRise && !hp.csN) begin
            if (!hp.advN) begin
              burstAddr <= hostAddr(mode, strap.bus32, hAddr, hReqLanes, hData[16:0]); // R4
            end else if (hRd || hWr) begin
              hostReqValid <= 1'b1;
              hostReq <= '{burstAddr, hReqLanes, hWr, hData}; // R16
              burstAddr <= burstAddr + hStep;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hostDataOut <= '0;
      hostDataOeN <= 1'b1;
    end else begin
      hostDataOut <= hostRdData;
      // in burst modes the drivers stay off while hostAdvN is low; in mux burst the lines carry the address then
      hostDataOeN <= !(!isMaster && mode != ext_bus_pkg::MODE_WAIT && !hp.csN && hRd &&
                       (isBurstSlave ? hp.advN : 1'b1));
    end
  end

  // memory master side
  assign step = isMstAsync || busTick; // R21
  assign twoBeats = !strap.bus32 && |cur.lanes[3:2];
  assign beatAddr = cur.addr + (beat ? ext_bus_pkg::ADDR_STEP16 : ext_bus_pkg::ADDR_ZERO);
  assign beatLanes = beat ? {2'b00, cur.lanes[3:2]} : cur.lanes;
  assign beatData = beat ? {16'h0000, cur.wdata[31:16]} : cur.wdata;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mState <= ext_bus_pkg::MS_IDLE;
      cur <= '0;
      beat <= 1'b0;
      holdCnt <= 3'h0;
      bootPending <= 1'b1;
      pageModeActive <= 1'b0;
      memReqReady <= 1'b0;
      memRespValid <= 1'b0;
      memRespErr <= 1'b0;
      memRespData <= '0;
      memAddr <= ext_bus_pkg::ADDR_ZERO;
      memDataOut <= '0;
      memDataOeN <= 1'b1;
      memChipSelectN <= ext_bus_pkg::CS_NONE_N;
      memRdN <= 1'b1;
      memWrStrobeN <= 1'b1;
      memLaneN <= ext_bus_pkg::LANES_ALL;
    end else begin
      unique case (mState)
        ext_bus_pkg::MS_IDLE: begin
          memRespValid <= 1'b0;
          memRespErr <= 1'b0;
          memReqReady <= isMaster;
          if (memReqValid && memReqReady) begin
            memReqReady <= 1'b0;
            cur <= memReq;
            beat <= 1'b0;
            // the async controller has no PSRAM or NOR flash timing
            if (isMstAsync && (memReq.kind == ext_bus_pkg::MEM_PSRAM ||
                               memReq.kind == ext_bus_pkg::MEM_NOR)) begin // R13 R14
              memRespValid <= 1'b1;
              memRespErr <= 1'b1;
            end else begin
              mState <= ext_bus_pkg::MS_ADDR;
              pageModeActive <= memReq.page && memReq.cs == 2'h0 &&
                                memReq.kind == ext_bus_pkg::MEM_PAGED_ROM; // R12
            end
          end
        end
        ext_bus_pkg::MS_ADDR: begin
          if (step) begin
            memChipSelectN <= bootPending ? ext_bus_pkg::CS0_ONLY_N :
                              ~(4'h1 << cur.cs); // R11
            if (isMstBurst && strap.admux) begin
              memAddr <= ext_bus_pkg::ADDR_ZERO;
              memDataOut <= {12'h000, beatAddr}; // R8
              memDataOeN <= 1'b0;
            end else begin
              memAddr <= beatAddr;
              memDataOut <= beatData;
              memDataOeN <= !cur.write;
            end
            mState <= ext_bus_pkg::MS_DATA;
          end
        end
        ext_bus_pkg::MS_DATA: begin
          if (step) begin
            holdCnt <= 3'h0;
            if (cur.write) begin
              memWrStrobeN <= 1'b0;
              memLaneN <= ~beatLanes; // R9
              memDataOut <= beatData;
              memDataOeN <= 1'b0;
            end else begin
              memRdN <= 1'b0;
              memLaneN <= strap.strobeFn ? ext_bus_pkg::LANES_ALL : ~beatLanes; // R9
              memDataOeN <= 1'b1;
            end
            mState <= ext_bus_pkg::MS_HOLD;
          end
        end
        ext_bus_pkg::MS_HOLD: begin
          // read data pass the pin synchroniser, so wait for it before sampling
          if (holdCnt != ext_bus_pkg::MEM_SYNC_WAIT) begin
            holdCnt <= holdCnt + 3'h1;
          end else if (step) begin
            if (strap.bus32) begin
              memRespData <= memDataSync;
            end else if (beat) begin
              memRespData[31:16] <= memDataSync[15:0];
            end else begin
              memRespData[15:0] <= memDataSync[15:0];
            end
            memRdN <= 1'b1;
            memWrStrobeN <= 1'b1;
            memLaneN <= ext_bus_pkg::LANES_ALL;
            if (twoBeats && !beat) begin
              beat <= 1'b1;
              if (pageModeActive) begin
                memAddr <= cur.addr + ext_bus_pkg::ADDR_STEP16; // R12
                mState <= ext_bus_pkg::MS_DATA;
              end else begin
                memChipSelectN <= ext_bus_pkg::CS_NONE_N;
                mState <= ext_bus_pkg::MS_ADDR;
              end
            end else begin
              memChipSelectN <= ext_bus_pkg::CS_NONE_N;
              memDataOeN <= 1'b1;
              mState <= ext_bus_pkg::MS_DONE;
            end
          end
        end
        ext_bus_pkg::MS_DONE: begin
          memRespValid <= 1'b1;
          bootPending <= 1'b0;
          pageModeActive <= 1'b0;
          mState <= ext_bus_pkg::MS_IDLE;
        end
      endcase
    end
  end

  a_role_master: // R1
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strapsDone) && !strap.role |=> isMaster)
    else $error("role strap low did not select a master mode");

  a_sync_sram_pick: // R2
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strapsDone) && strap.role && !strap.ctlType |=>
        mode == (strap.hostSync ? ext_bus_pkg::MODE_SLV_SYNC : ext_bus_pkg::MODE_SLV_ASYNC))
    else $error("SRAM slave style does not follow the sync strap");

  a_burst_slave: // R3
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strapsDone) && strap.role && strap.ctlType && strap.hostSync |=> isBurstSlave)
    else $error("burst slave mode not selected");

  a_burst_mux_sel: // R4
    assert property (@(posedge core_clk) disable iff (!rst_n)
      isBurstSlave |-> (mode == ext_bus_pkg::MODE_SLV_BURST_MUX) == strap.admux)
    else $error("burst slave mux form differs from strap");

  a_async_master: // R6
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strapsDone) && !strap.role && !strap.ctlType |=> ##1 modeOut == ext_bus_pkg::MODE_MST_ASYNC)
    else $error("async master controller not selected");

  a_burst_master: // R7
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strapsDone) && !strap.role && strap.ctlType |=> ##1 modeOut == ext_bus_pkg::MODE_MST_BURST)
    else $error("burst master controller not selected");

  a_mux_addr_data: // R8
    assert property (@(posedge core_clk) disable iff (!rst_n)
      mState == ext_bus_pkg::MS_ADDR && step && isMstBurst && strap.admux |=>
        !memDataOeN && memAddr == ext_bus_pkg::ADDR_ZERO && memDataOut[19:0] == $past(beatAddr))
    else $error("address not placed on data lines in mux burst");

  a_read_no_strobe: // R9
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !memRdN && strap.strobeFn |-> memLaneN == ext_bus_pkg::LANES_ALL && memWrStrobeN)
    else $error("write strobes active during a read");

  a_boot_cs_zero: // R11
    assert property (@(posedge core_clk) disable iff (!rst_n)
      bootPending && memChipSelectN != ext_bus_pkg::CS_NONE_N |->
        memChipSelectN == ext_bus_pkg::CS0_ONLY_N)
    else $error("boot access not on chip select zero");

  a_page_cs_zero: // R12
    assert property (@(posedge core_clk) disable iff (!rst_n)
      pageModeActive |-> memChipSelectN[3:1] == 3'h7)
    else $error("page mode on a chip select other than zero");

  a_bus_clock_gate: // R21
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !isMstBurst |=> !extBusClock)
    else $error("bus clock runs outside master burst mode");
endmodule

// >>> design/ext_bus_pkg.sv
// constants, types and structs shared by the external bus mode port
// Overview of operation
// R1: role strap high slave, low master
// R2: slave, type low: sync pin picks SRAM style
// R3: role and type high give burst slave; code also needs the sync pin high, else it decodes the prohibited mode
// R4: burst slave: mux pin shares address, data
// R5: board never straps prohibited combination
// R6: both type and role low: async controller
// R7: type high, role low: burst controller
// R8: master burst: mux pin puts address on data
// R9: strobe pin selects write strobes or enables
// R10: board holds strobe select low in burst
// R11: boot pins low: boot from chip select 0
// R12: paged ROM page mode only on select 0
// R13: async controller: ROM, SRAM types, 16/32 bits
// R14: burst controller adds PSRAM and NOR flash
// R15: system picks sync SRAM before fieldbus access
// R16: burst slave decodes byte granular addresses
// R17: mux burst: line 17 carries address bit 17
// R18: separated burst: line 1 is word/half bit
// R19: SRAM slave: line 2, line 1 boundary bits
// R20: host may wire error output to interrupt
// R21: master burst drives bus clock for transfers
package ext_bus_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int HADDR_HI = 17;
  localparam int CORE_CLK_NS = 5;
  localparam int BUS_CLK_NS = 20;
  localparam logic [3:0] BUS_CLK_HALF = 4'(BUS_CLK_NS / (2 * CORE_CLK_NS));
  localparam logic [2:0] STRAP_SETTLE = 3'h4;
  localparam logic [2:0] MEM_SYNC_WAIT = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;
  localparam logic [ADDR_W-1:0] ADDR_STEP16 = 20'h00002;
  localparam logic [ADDR_W-1:0] ADDR_STEP32 = 20'h00004;
  localparam logic [3:0] LANES_ALL = 4'hF;
  localparam logic [3:0] CS_NONE_N = 4'hF;
  localparam logic [3:0] CS0_ONLY_N = 4'hE;
  localparam logic [8:0] HOST_CTL_IDLE = 9'h0FF;
  localparam logic [2:0] MEM_ROM = 3'h0;
  localparam logic [2:0] MEM_PAGED_ROM = 3'h1;
  localparam logic [2:0] MEM_SRAM = 3'h2;
  localparam logic [2:0] MEM_SRAM_LIKE = 3'h3;
  localparam logic [2:0] MEM_PSRAM = 3'h4;
  localparam logic [2:0] MEM_NOR = 3'h5;

  typedef enum logic [7:0] {
    MODE_WAIT = 8'h01,
    MODE_MST_ASYNC = 8'h02,
    MODE_MST_BURST = 8'h04,
    MODE_SLV_ASYNC = 8'h08,
    MODE_SLV_SYNC = 8'h10,
    MODE_SLV_BURST_SEP = 8'h20,
    MODE_SLV_BURST_MUX = 8'h40,
    MODE_PROHIBITED = 8'h80
  } mode_e;

  typedef enum logic [4:0] {
    MS_IDLE = 5'h01,
    MS_ADDR = 5'h02,
    MS_DATA = 5'h04,
    MS_HOLD = 5'h08,
    MS_DONE = 5'h10
  } mst_state_e;

  typedef struct packed {
    logic role;
    logic ctlType;
    logic hostSync;
    logic admux;
    logic strobeFn;
    logic boot_select_0;
    logic boot_select_1;
    logic bus32;
  } strap_s;

  typedef struct packed {
    logic clk;
    logic csN;
    logic rdN;
    logic wrN;
    logic advN;
    logic [3:0] strobeN;
  } host_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0] lanes;
    logic write;
    logic [DATA_W-1:0] data;
  } host_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] lanes;
    logic write;
    logic [1:0] cs;
    logic page;
    logic [2:0] kind;
  } mem_req_s;
endpackage

// >>> design/pin_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and settled levels
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] s1, s2, s3;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pinOut[i] <= RST_VAL[i];
      end else if (s2[i] == s3[i]) begin
        pinOut[i] <= s3[i];
      end
    end
  end
endmodule

// >>> dv/ext_mem_model.sv
// external memory model on the master pins, data derived from the address
module ext_mem_model (
  // mode
  input wire logic muxed,
  // memory pins
  input wire logic [19:0] memAddr,
  input wire logic [31:0] memDataOut,
  input wire logic memDataOeN,
  input wire logic [3:0] memChipSelectN,
  input wire logic memRdN,
  output logic [31:0] memDataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [19:0] muxAddr = 20'h00000;
  logic [31:0] last = 32'h00000000;
  logic [19:0] ea;
  logic sel;
  assign sel = !memRdN && memChipSelectN != 4'hF;
  // address phase arrives on the shared lines
  always @(memDataOut or memDataOeN or memChipSelectN) begin
    if (muxed && !memDataOeN && memChipSelectN != 4'hF) muxAddr = memDataOut[19:0];
  end
  assign ea = muxed ? muxAddr : memAddr;
  // released bus shows the inverse of the last word, so a late capture is caught
  assign memDataIn = sel ? {~ea[11:0], ea} : ~last;
  always @(memDataIn) begin
    if (sel) last = memDataIn;
  end
endmodule

// >>> dv/test_ext_bus_mode_select.sv
// self-checking bench for the strap-selected external bus port
module test_ext_bus_mode_select;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst_n = 1'b0, hostClk = 1'b0, hostRun = 1'b0, memReqValid = 1'b0;
  logic [7:0] strap = 8'h00;
  logic [3:0] hc = 4'hF, hostStrobeN = 4'hF, memChipSelectN;
  logic [17:1] hostAddrLine = '0;
  logic [31:0] hostDataIn = '0, hostRdData = '0, rnd = 32'h909BD5C0, memDataIn, memDataOut;
  logic [31:0] memRespData, hostDataOut;
  logic [19:0] memAddr;
  logic hostReqValid, memReqReady, memRespValid, memRespErr, extBusClock, memDataOeN, memRdN;
  logic cfgError, hostErrorOutN, bootFromCs0;
  ext_bus_pkg::host_req_s hostReq;
  ext_bus_pkg::mem_req_s memReq = '0;
  ext_bus_pkg::mode_e modeOut;
  int n_mismatch = 0, n_tests = 0, cyc = 0, nClk = 0;
  logic [19:0] hostQ[$];
  logic [32:0] memQ[$];
  logic [32:0] e;

  ext_bus_mode_select ext_bus_mode_select_inst (.core_clk(core_clk), .rst_n(rst_n),
    .ifcRoleSelect(strap[7]), .memctlTypeSelect(strap[6]), .hostSyncSelect(strap[5]),
    .addrDataMuxSelect(strap[4]), .strobeFunctionSelect(strap[3]), .bootSelect0(strap[2]),
    .bootSelect1(strap[1]), .hostBus32(strap[0]), .hostClk(hostClk), .hostCsN(hc[3]),
    .hostRdN(hc[2]), .hostWrN(hc[1]), .hostAdvN(hc[0]), .hostStrobeN(hostStrobeN),
    .hostAddrLine(hostAddrLine), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOeN(), .hostErrorOutN(hostErrorOutN), .hostReqValid(hostReqValid), .hostReq(hostReq),
    .hostRdData(hostRdData), .memReqValid(memReqValid), .memReq(memReq),
    .memReqReady(memReqReady), .memRespValid(memRespValid), .memRespErr(memRespErr),
    .memRespData(memRespData), .extBusClock(extBusClock), .memAddr(memAddr),
    .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOeN(memDataOeN),
    .memChipSelectN(memChipSelectN), .memRdN(memRdN), .memWrStrobeN(), .memLaneN(),
    .modeOut(modeOut), .cfgError(cfgError), .bootFromCs0(bootFromCs0), .pageModeActive());
  ext_mem_model ext_mem_model_inst (.muxed(strap[4]), .memAddr(memAddr),
    .memDataOut(memDataOut), .memDataOeN(memDataOeN), .memChipSelectN(memChipSelectN),
    .memRdN(memRdN), .memDataIn(memDataIn));

  initial forever #2.5 core_clk = ~core_clk;
  // host link clock stands still low between frames
  always #32 hostClk = hostRun & ~hostClk;
  always @(posedge extBusClock) nClk++;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (hostReqValid === 1'b1) chk(33'(hostReq.addr), hostQ.size() ? 33'(hostQ.pop_front()) : 'x);
    if (memRespValid === 1'b1) begin
      e = memQ.size() ? memQ.pop_front() : 'x;
      chk({memRespErr, e[32] ? 32'h0 : memRespData}, {e[32], e[32] ? 32'h0 : e[31:0]});
    end
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // straps must settle while reset is held
  task automatic start(input logic [7:0] s);
    rst_n = 1'b0;
    strap = s;
    step(10);
    rst_n = 1'b1;
    step(12);
  endtask

  task automatic hb(input logic [3:0] c, input logic [3:0] st, input logic [17:1] a,
                    input logic [31:0] d);
    @(negedge hostClk);
    hc = c;
    hostStrobeN = st;
    hostAddrLine = a;
    hostDataIn = d;
  endtask

  task automatic mreq(input logic [19:0] a, input logic [1:0] cs, input logic [2:0] k,
                      input logic err, input logic [3:0] ecs);
    logic [3:0] seen;
    seen = 4'hF;
    memQ.push_back({err, ~a[11:0], a});
    memReq = '{addr: a, wdata: rnd, lanes: 4'hF, write: 1'b0, cs: cs, page: 1'b0, kind: k};
    memReqValid = 1'b1;
    for (int i = 0; i < 100 && memReqReady !== 1'b1; i++) step(1);
    step(1);
    memReqValid = 1'b0;
    for (int i = 0; i < 100 && memRespValid !== 1'b1; i++) begin
      if (memChipSelectN !== 4'hF) seen = memChipSelectN;
      step(1);
    end
    chk(33'(seen), 33'(ecs));
    step(2);
  endtask

  initial begin
    logic [3:0] m;
    logic [7:0] em;
    logic c;
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      rnd = lfsr(rnd);
      start({m, rnd[0], rnd[1], rnd[2], 1'b1});
      em = !m[3] ? (m[2] ? 8'h04 : 8'h02) : !m[2] ? (m[1] ? 8'h10 : 8'h08) :
           !m[1] ? 8'h80 : m[0] ? 8'h40 : 8'h20;
      c = m[3] & m[2] & (!m[1] | rnd[0]);
      chk(33'(modeOut), 33'(em));
      chk(33'({cfgError, hostErrorOutN}), 33'({c, !c}));
      if (!m[3]) chk(33'(bootFromCs0), 33'(!rnd[1] && !rnd[2]));
      nClk = 0;
      step(40);
      chk(33'(nClk), (m[3:2] == 2'b01) ? 33'hA : 33'h0);
    end
    start(8'hA9);
    hostRun = 1'b1;
    rnd = lfsr(rnd);
    hostRdData = ~rnd;
    hostQ.push_back({2'b00, rnd[17:2], 2'b10});
    hb(4'h5, 4'hB, rnd[17:1], rnd);
    hb(4'hF, 4'hF, rnd[17:1], rnd);
    hb(4'hF, 4'hF, rnd[17:1], rnd);
    chk(33'(hostDataOut), 33'(hostRdData));
    hostRun = 1'b0;
    start(8'hF1);
    hostRun = 1'b1;
    rnd = lfsr(rnd);
    hostQ.push_back({2'b00, rnd[31], rnd[16:0]});
    hb(4'h6, 4'h0, {rnd[31], 16'h0000}, rnd);
    hb(4'h5, 4'h0, {rnd[31], 16'h0000}, ~rnd);
    hb(4'hF, 4'hF, {rnd[31], 16'h0000}, ~rnd);
    hostRun = 1'b0;
    step(12);
    start(8'h09);
    rnd = lfsr(rnd);
    mreq({rnd[19:2], 2'b00}, 2'd2, ext_bus_pkg::MEM_SRAM, 1'b0, ext_bus_pkg::CS0_ONLY_N);
    mreq({rnd[31:14], 2'b00}, 2'd0, ext_bus_pkg::MEM_NOR, 1'b1, 4'hF);
    start(8'h51);
    mreq({rnd[27:10], 2'b00}, 2'd0, ext_bus_pkg::MEM_SRAM, 1'b0, ext_bus_pkg::CS0_ONLY_N);
    test_done();
  end
endmodule
